// [hw/drw_pkg.sv]
package drw_pkg;
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 32;
    localparam int NARROW_W    = 16;
    localparam int REG_IDX_W   = 4;
    localparam int MODE_MSB    = 15;
    localparam int MODE_LSB    = 12;
    localparam int CLK_PERIOD_NS       = 8;
    localparam int SETUP_NS            = 360;
    localparam int STROBE_HOLD_NS      = 300;
    localparam int RELEASE_NS          = 200;
    localparam int SETUP_CYC   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC    = (STROBE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W       = 8;
    localparam logic [3:0] MODE_INTERNAL = 4'h0;
    localparam logic [3:0] MODE_INTR     = 4'h1;
    localparam logic [3:0] MODE_STD_LO   = 4'hC;
    localparam logic [3:0] MODE_STD_HI   = 4'hE;
    localparam logic [3:0] MODE_SPECIAL  = 4'hF;
    localparam logic [3:0] ZERO_REG      = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
endpackage

// [hw/drw_bus_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface drw_bus_if;
    logic [15:0] addr;
    logic        write_not_read_line;
    logic        strobe;
    logic        host_rst;
    logic [31:0] host_data_o;
    logic        host_data_oe_n;
    logic [31:0] unit_data_o;
    logic        unit_data_oe_n;
    logic        unit_cc_a_o;
    logic        unit_cc_b_o;
    logic        unit_ack_o;
    logic        unit_oe_n;
    // Wired-OR resolution: an enabled driver puts its value on the lines, idle lines rest at zero.
    logic [31:0] data;
    logic        cond_code_bit_a;
    logic        cond_code_bit_b;
    logic        ack;
    assign data = (host_data_oe_n ? 32'h0000_0000 : host_data_o)
                | (unit_data_oe_n ? 32'h0000_0000 : unit_data_o);
    assign cond_code_bit_a = ~unit_oe_n & unit_cc_a_o;
    assign cond_code_bit_b = ~unit_oe_n & unit_cc_b_o;
    assign ack = ~unit_oe_n & unit_ack_o;
    modport computer (
        output addr, write_not_read_line, strobe, host_rst, host_data_o, host_data_oe_n,
        input  data, cond_code_bit_a, cond_code_bit_b, ack
    );
    modport unit (
        input  addr, write_not_read_line, strobe, host_rst, data,
        output unit_data_o, unit_data_oe_n, unit_cc_a_o, unit_cc_b_o, unit_ack_o, unit_oe_n
    );
endinterface
`default_nettype wire

// [hw/drw_unit.sv]
`timescale 1ns/10ps
`default_nettype none
module drw_unit #(
    parameter logic [15:0] UNIT_ADDR = 16'hC000
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    drw_bus_if.unit          bus,
    input  wire logic [31:0] i_rd_data,
    input  wire logic        i_cc_a,
    input  wire logic        i_cc_b,
    output logic [31:0]      o_wr_data,
    output logic             o_wr_valid,
    output logic             o_rd_taken
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [15:0] addr_s1_r, addr_s2_r;
    logic        wnr_s1_r, wnr_s2_r, stb_s1_r, stb_s2_r, stb_d_r;
    logic [31:0] data_s1_r, data_s2_r;
    logic        hit_r;

    if (UNIT_ADDR[drw_pkg::MODE_MSB:drw_pkg::MODE_LSB] < drw_pkg::MODE_STD_LO) begin : g_mode_check
        $error("unit address lies in a computer or unassigned control mode");
    end

    always_ff @(posedge i_core_clk) begin
        addr_s1_r <= bus.addr;
        addr_s2_r <= addr_s1_r;
        wnr_s1_r  <= bus.write_not_read_line;
        wnr_s2_r  <= wnr_s1_r;
        stb_s1_r  <= bus.strobe;
        stb_s2_r  <= stb_s1_r;
        data_s1_r <= bus.data;
        data_s2_r <= data_s1_r;
        if (i_sys_rst) begin
            stb_d_r <= 1'b0;
        end else begin
            stb_d_r <= stb_s2_r;
        end
    end

    // ---------------------------------------------------------------
    // Answer drivers
    // ---------------------------------------------------------------
    // full address match
    assign hit_r = (addr_s2_r == UNIT_ADDR);
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || bus.host_rst) begin
            bus.unit_oe_n      <= 1'b1;
            bus.unit_data_oe_n <= 1'b1;
            bus.unit_ack_o     <= 1'b0;
            bus.unit_cc_a_o    <= 1'b0;
            bus.unit_cc_b_o    <= 1'b0;
            bus.unit_data_o    <= drw_pkg::DATA_ZERO;
        end else if (stb_s2_r && hit_r) begin
            bus.unit_oe_n      <= 1'b0;
            bus.unit_data_oe_n <= wnr_s2_r;
            bus.unit_ack_o     <= 1'b1;
            bus.unit_cc_a_o    <= i_cc_a;
            bus.unit_cc_b_o    <= i_cc_b;
            bus.unit_data_o    <= wnr_s2_r ? drw_pkg::DATA_ZERO : i_rd_data;
        end else begin
            bus.unit_oe_n      <= 1'b1;
            bus.unit_data_oe_n <= 1'b1;
            bus.unit_ack_o     <= 1'b0;
            bus.unit_cc_a_o    <= 1'b0;
            bus.unit_cc_b_o    <= 1'b0;
            bus.unit_data_o    <= drw_pkg::DATA_ZERO;
        end
    end

    // ---------------------------------------------------------------
    // User side, captured at the trailing strobe edge
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_wr_data  <= drw_pkg::DATA_ZERO;
            o_wr_valid <= 1'b0;
            o_rd_taken <= 1'b0;
        end else begin
            o_wr_valid <= 1'b0;
            o_rd_taken <= 1'b0;
            if (stb_d_r && !stb_s2_r && hit_r) begin
                o_wr_valid <= wnr_s2_r;
                o_rd_taken <= !wnr_s2_r;
                if (wnr_s2_r) begin
                    o_wr_data <= data_s2_r;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hw/drw_computer.sv]
`timescale 1ns/10ps
`default_nettype none
module drw_computer #(
    parameter bit NARROW = 1'b0
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    drw_bus_if.computer      bus,
    input  wire logic        i_req,
    input  wire logic        i_write,
    input  wire logic [15:0] i_addr,
    input  wire logic [3:0]  i_reg_sel,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_io_reset,
    output logic             o_busy,
    output logic             o_done,
    output logic [31:0]      o_rd_data,
    output logic             o_rd_load,
    output logic [3:0]       o_rd_reg,
    output logic             o_cc_a,
    output logic             o_cc_b,
    output logic [3:0]       o_mode
);
    typedef enum logic [4:0] {
        DRW_IDLE  = 5'b00001,
        DRW_SETUP = 5'b00010,
        DRW_STB   = 5'b00100,
        DRW_HOLD  = 5'b01000,
        DRW_REL   = 5'b10000
    } drw_state_t;

    drw_state_t state_r;
    logic [drw_pkg::CNT_W-1:0] cnt_r;
    logic        wr_r;
    logic [3:0]  reg_r;
    logic        ack_s1_r, ack_s2_r, cca_s1_r, cca_s2_r, ccb_s1_r, ccb_s2_r;
    logic [31:0] din_s1_r, din_s2_r;

    // Every timing count must fit the shared counter.
    if (drw_pkg::SETUP_CYC >= (1 << drw_pkg::CNT_W) ||
        drw_pkg::HOLD_CYC >= (1 << drw_pkg::CNT_W) ||
        drw_pkg::RELEASE_CYC >= (1 << drw_pkg::CNT_W)) begin : g_cnt_check
        $error("counter too narrow for the timing counts");
    end

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        ack_s1_r <= bus.ack;
        ack_s2_r <= ack_s1_r;
        cca_s1_r <= bus.cond_code_bit_a;
        cca_s2_r <= cca_s1_r;
        ccb_s1_r <= bus.cond_code_bit_b;
        ccb_s2_r <= ccb_s1_r;
        din_s1_r <= bus.data;
        din_s2_r <= din_s1_r;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            bus.host_rst <= 1'b1;
        end else begin
            bus.host_rst <= i_io_reset;
        end
    end

    // ---------------------------------------------------------------
    // Transfer sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_r <= DRW_IDLE;
            cnt_r   <= '0;
            wr_r    <= 1'b0;
            reg_r   <= drw_pkg::ZERO_REG;
        end else begin
            case (state_r)
                DRW_IDLE: begin
                    cnt_r <= '0;
                    if (i_req) begin
                        wr_r    <= i_write;
                        reg_r   <= i_reg_sel;
                        state_r <= DRW_SETUP;
                    end
                end
                DRW_SETUP: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == drw_pkg::CNT_W'(drw_pkg::SETUP_CYC - 1)) begin
                        cnt_r   <= '0;
                        state_r <= DRW_STB;
                    end
                end
                DRW_STB: begin
                    if (ack_s2_r) begin
                        state_r <= DRW_HOLD;
                    end
                end
                DRW_HOLD: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == drw_pkg::CNT_W'(drw_pkg::HOLD_CYC - 1)) begin
                        cnt_r   <= '0;
                        state_r <= DRW_REL;
                    end
                end
                DRW_REL: begin
                    if (ack_s2_r) begin
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r == drw_pkg::CNT_W'(drw_pkg::RELEASE_CYC - 1)) begin
                            state_r <= DRW_IDLE;
                        end
                    end
                end
                default: state_r <= DRW_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Bus drivers
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            bus.addr                <= drw_pkg::ADDR_ZERO;
            bus.write_not_read_line <= 1'b0;
            bus.strobe              <= 1'b0;
            bus.host_data_o         <= drw_pkg::DATA_ZERO;
            bus.host_data_oe_n      <= 1'b1;
            o_mode                  <= drw_pkg::MODE_INTERNAL;
        end else if (state_r == DRW_IDLE && i_req) begin
            bus.addr                <= i_addr;
            bus.write_not_read_line <= i_write;
            o_mode                  <= i_addr[drw_pkg::MODE_MSB:drw_pkg::MODE_LSB];
            if (i_write && i_reg_sel != drw_pkg::ZERO_REG) begin
                bus.host_data_o <= NARROW ? {16'h0000, i_wr_data[15:0]} : i_wr_data;
            end else begin
                bus.host_data_o <= drw_pkg::DATA_ZERO;
            end
            bus.host_data_oe_n      <= ~i_write;
        end else if (state_r == DRW_SETUP) begin
            bus.strobe <= (cnt_r == drw_pkg::CNT_W'(drw_pkg::SETUP_CYC - 1));
        end else if (state_r == DRW_HOLD &&
                     cnt_r == drw_pkg::CNT_W'(drw_pkg::HOLD_CYC - 1)) begin
            bus.strobe <= 1'b0;
        end else if (state_r == DRW_REL && !ack_s2_r &&
                     cnt_r == drw_pkg::CNT_W'(drw_pkg::RELEASE_CYC - 1)) begin
            bus.addr                <= drw_pkg::ADDR_ZERO;
            bus.write_not_read_line <= 1'b0;
            bus.host_data_o         <= drw_pkg::DATA_ZERO;
            bus.host_data_oe_n      <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Result capture
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= drw_pkg::DATA_ZERO;
            o_rd_load <= 1'b0;
            o_rd_reg  <= drw_pkg::ZERO_REG;
            o_cc_a    <= 1'b0;
            o_cc_b    <= 1'b0;
            o_done    <= 1'b0;
            o_busy    <= 1'b0;
        end else begin
            o_rd_load <= 1'b0;
            o_done    <= 1'b0;
            o_busy    <= (state_r != DRW_IDLE) || i_req;
            if (state_r == DRW_STB && ack_s2_r) begin
                o_cc_a   <= cca_s2_r;
                o_cc_b   <= ccb_s2_r;
                o_rd_reg <= reg_r;
                if (!wr_r && reg_r != drw_pkg::ZERO_REG) begin
                    o_rd_data <= NARROW ? {16'h0000, din_s2_r[15:0]} : din_s2_r;
                    o_rd_load <= 1'b1;
                end
            end
            if (state_r == DRW_REL && !ack_s2_r &&
                cnt_r == drw_pkg::CNT_W'(drw_pkg::RELEASE_CYC - 1)) begin
                o_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/drw_bus_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module drw_bus_asserts (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] addr,
    input  wire logic        write_not_read_line,
    input  wire logic        strobe,
    input  wire logic        host_data_oe_n,
    input  wire logic        unit_data_oe_n,
    input  wire logic        unit_oe_n,
    input  wire logic [31:0] data,
    input  wire logic        ack
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // ------------------------------------------------------------
    // Acknowledge low time
    // ------------------------------------------------------------
    logic [7:0] ack_low_r;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || ack) begin
            ack_low_r <= 8'h00;
        end else if (ack_low_r != 8'hFF) begin
            ack_low_r <= ack_low_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    a_setup_before_strobe: assert property (
        $rose(strobe) |-> addr != 16'h0000 && $past(addr, 45) == addr
            && $past(write_not_read_line, 45) == write_not_read_line)
        else $error("strobe rose before the address setup time");
    a_strobe_hold: assert property (
        $fell(strobe) |-> $past(ack, 38) && $past(strobe, 38))
        else $error("strobe dropped too soon after acknowledge");
    a_lines_steady: assert property (
        strobe |-> $stable(addr) && $stable(write_not_read_line))
        else $error("address or direction moved under strobe");
    a_write_data_held: assert property (
        (strobe && write_not_read_line) |-> $stable(data))
        else $error("write data moved under strobe");
    a_read_no_drive: assert property (
        (strobe && !write_not_read_line) |-> host_data_oe_n)
        else $error("computer drives data during a read");
    a_ack_gated: assert property (
        $rose(ack) |-> strobe)
        else $error("acknowledge rose without strobe");
    a_unit_release: assert property (
        $fell(strobe) |-> ##[1:6] (!ack && unit_oe_n && unit_data_oe_n))
        else $error("unit did not release after strobe fell");
    a_addr_release: assert property (
        ($past(addr) != 16'h0000 && addr == 16'h0000) |-> ack_low_r >= 8'h18)
        else $error("address dropped too soon after acknowledge fell");
    a_idle_quiet: assert property (
        (addr == 16'h0000) |-> host_data_oe_n && unit_data_oe_n && !ack
            && data == 32'h0000_0000)
        else $error("idle bus is not quiet");
endmodule
`default_nettype wire

// [verif/tb_direct_read_write_port.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_direct_read_write_port;
    localparam logic [15:0] UNIT_ADDR = 16'hC0A5;
    logic        i_core_clk;
    logic        i_sys_rst;
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  reg_sel;
    logic [31:0] wr_data;
    logic        io_reset;
    logic [31:0] rd_data;
    logic        cc_a;
    logic        cc_b;
    logic        busy;
    logic        done;
    logic [31:0] c_rd_data;
    logic        rd_load;
    logic [3:0]  c_rd_reg;
    logic        c_cc_a;
    logic        c_cc_b;
    logic [3:0]  mode;
    logic [31:0] u_wr_data;
    logic        wr_valid;
    logic        rd_taken;
    logic [31:0] n_rd_data;
    logic        n_cc_a;
    logic        n_cc_b;
    logic [31:0] n_wr_data;
    int          fail_count;
    int          checks;
    int          i;

    drw_bus_if drw_bus_if_i ();
    drw_computer #(.NARROW(1'b0)) drw_computer_i (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .bus(drw_bus_if_i),
        .i_req(req), .i_write(wr), .i_addr(addr), .i_reg_sel(reg_sel),
        .i_wr_data(wr_data), .i_io_reset(io_reset), .o_busy(busy), .o_done(done),
        .o_rd_data(c_rd_data), .o_rd_load(rd_load), .o_rd_reg(c_rd_reg),
        .o_cc_a(c_cc_a), .o_cc_b(c_cc_b), .o_mode(mode));
    drw_unit #(.UNIT_ADDR(UNIT_ADDR)) drw_unit_i (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .bus(drw_bus_if_i),
        .i_rd_data(rd_data), .i_cc_a(cc_a), .i_cc_b(cc_b), .o_wr_data(u_wr_data),
        .o_wr_valid(wr_valid), .o_rd_taken(rd_taken));
    drw_bus_asserts drw_bus_asserts_i (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .addr(drw_bus_if_i.addr),
        .write_not_read_line(drw_bus_if_i.write_not_read_line),
        .strobe(drw_bus_if_i.strobe), .host_data_oe_n(drw_bus_if_i.host_data_oe_n),
        .unit_data_oe_n(drw_bus_if_i.unit_data_oe_n), .unit_oe_n(drw_bus_if_i.unit_oe_n),
        .data(drw_bus_if_i.data), .ack(drw_bus_if_i.ack));

    // The narrow variant runs on a bus of its own, fed by the same requests.
    drw_bus_if drw_bus_if_narrow_i ();
    drw_computer #(.NARROW(1'b1)) drw_computer_narrow_i (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .bus(drw_bus_if_narrow_i),
        .i_req(req), .i_write(wr), .i_addr(addr), .i_reg_sel(reg_sel),
        .i_wr_data(wr_data), .i_io_reset(io_reset), .o_busy(), .o_done(),
        .o_rd_data(n_rd_data), .o_rd_load(), .o_rd_reg(),
        .o_cc_a(n_cc_a), .o_cc_b(n_cc_b), .o_mode());
    drw_unit #(.UNIT_ADDR(UNIT_ADDR)) drw_unit_narrow_i (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .bus(drw_bus_if_narrow_i),
        .i_rd_data(rd_data), .i_cc_a(cc_a), .i_cc_b(cc_b), .o_wr_data(n_wr_data),
        .o_wr_valid(), .o_rd_taken());

    // ------------------------------------------------------------
    // Checking and reporting
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // One complete transfer, started at a falling edge
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [3:0] r, input logic [31:0] d,
                        input logic [1:0] cc);
        int          n;
        logic        load_seen;
        logic        unit_seen;
        logic [31:0] line_seen;
        n = 0;
        load_seen = 1'b0;
        unit_seen = 1'b0;
        line_seen = 32'h0000_0000;
        rd_data = d;
        {cc_a, cc_b} = cc;
        wr = w;
        addr = UNIT_ADDR;
        reg_sel = r;
        wr_data = d;
        req = 1'b1;
        @(negedge i_core_clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge i_core_clk);
            n++;
            load_seen |= (rd_load === 1'b1);
            unit_seen |= (w ? wr_valid === 1'b1 : rd_taken === 1'b1);
            if (drw_bus_if_i.ack === 1'b1 && drw_bus_if_i.strobe === 1'b1) begin
                line_seen = drw_bus_if_i.data;
            end
        end
        check("done", {31'h0, done}, 32'h1);
        check("bus data", line_seen, (w && r == 4'h0) ? 32'h0 : d);
        check("cond codes", {30'h0, c_cc_a, c_cc_b}, {30'h0, cc});
        check("narrow cond codes", {30'h0, n_cc_a, n_cc_b}, {30'h0, cc});
        check("mode", {28'h0, mode}, {28'h0, UNIT_ADDR[15:12]});
        check("unit end", {31'h0, unit_seen}, 32'h1);
        if (w) begin
            check("unit wr data", u_wr_data, (r == 4'h0) ? 32'h0 : d);
            check("narrow wr data", n_wr_data, (r == 4'h0) ? 32'h0 : {16'h0, d[15:0]});
        end else begin
            check("rd load", {31'h0, load_seen}, {31'h0, r != 4'h0});
            if (r != 4'h0) begin
                check("rd data", c_rd_data, d);
                check("narrow rd data", n_rd_data, {16'h0, d[15:0]});
                check("rd reg", {28'h0, c_rd_reg}, {28'h0, r});
            end
        end
        $display("Transfer write %b reg %h done", w, r);
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    initial begin
        repeat (6000) @(posedge i_core_clk);
        fail_count++;
        $display("Error watchdog expected finish seen timeout");
        final_report;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {req, wr, addr, reg_sel, wr_data, io_reset, rd_data, cc_a, cc_b} = '0;
        fail_count = 0;
        checks = 0;
        i_sys_rst = 1'b1;
        repeat (10) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        @(negedge i_core_clk);
        for (i = 0; i < 8; i++) begin
            xfer(i[2], {i[1:0], i[1:0]}, 32'hA5C3_0F96 ^ {8{i[3:0]}}, i[1:0] + 2'h1);
        end
        // A unit one address bit away must stay silent.
        addr = UNIT_ADDR ^ 16'h0001;
        wr = 1'b0;
        req = 1'b1;
        @(negedge i_core_clk);
        req = 1'b0;
        repeat (120) @(negedge i_core_clk);
        check("strobe", {31'h0, drw_bus_if_i.strobe}, 32'h1);
        check("unmatched ack", {31'h0, drw_bus_if_i.ack}, 32'h0);
        check("unmatched data", drw_bus_if_i.data, 32'h0);
        $display("Unmatched address test done");
        io_reset = 1'b1;
        repeat (3) @(negedge i_core_clk);
        check("io reset", {31'h0, drw_bus_if_i.host_rst}, 32'h1);
        io_reset = 1'b0;
        i_sys_rst = 1'b1;
        repeat (10) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        @(negedge i_core_clk);
        check("busy", {31'h0, busy}, 32'h0);
        $display("Mid-run reset test done");
        xfer(1'b0, 4'h7, 32'h0123_4567, 2'h2);
        final_report;
    end
endmodule
`default_nettype wire
